// >>> rtl/ethmh_crc_hash.sv
// Purpose: CRC-32 hash of a 48-bit destination address
// Assumes: Address bytes in wire order, first byte in bits 7:0, each byte sent LSB first
// Notes:   Purely combinational; the loop unrolls into an xor tree
`timescale 1ns/1ps
module ethmh_crc_hash
    import ethmh_pkg::*;
(
    ethmh_hash_if.hasher hif // Address in, index out
);
    function automatic logic [31:0] ethmh_crc48(input logic [47:0] addr);
        logic [31:0] crc;
        logic        fb;
        crc = ETHMH_CRC_INIT;
        for (int i = 0; i < 48; i++) begin
            fb  = crc[31] ^ addr[i];
            crc = {crc[30:0], 1'b0} ^ (fb ? ETHMH_CRC_POLY : 32'h00000000);
        end
        return crc;
    endfunction : ethmh_crc48

    wire [31:0] crc_val = ethmh_crc48(hif.dest_addr);

    assign hif.hash_index = crc_val[31:26];
endmodule : ethmh_crc_hash

// >>> rtl/ethmh_hash_if.sv
// Purpose: Carries a destination address to the hash unit and its index back
// Assumes: Single clock, combinational lookup
// Notes:   Owner side drives the address, hash side answers the index
`timescale 1ns/1ps
interface ethmh_hash_if;
    logic [47:0] dest_addr;
    logic [5:0]  hash_index;
    modport owner (output dest_addr, input hash_index);
    modport hasher (input dest_addr, output hash_index);
endinterface : ethmh_hash_if

// >>> rtl/ethmh_pkg.sv
// Purpose: Shared constants for the early threshold and multicast hash block
// Assumes: Avalon-MM slave, 32-bit data, one register per aligned word
// Notes:   Offsets are 16-bit bank offsets; byte address is four times the word index
package ethmh_pkg;

    // Register word indices within a bank; address bit 4 tells the two banks apart
    localparam logic [3:0] ETHMH_IDX_HASH0     = 4'h0;
    localparam logic [3:0] ETHMH_IDX_HASH1     = 4'h2;
    localparam logic [3:0] ETHMH_IDX_HASH2     = 4'h4;
    localparam logic [3:0] ETHMH_IDX_HASH3     = 4'h6;
    localparam logic [3:0] ETHMH_IDX_ETX       = 4'h8;
    localparam logic [3:0] ETHMH_IDX_ERX       = 4'ha;
    localparam logic [3:0] ETHMH_IDX_RXCTL     = 4'hc;
    localparam logic [3:0] ETHMH_IDX_STATUS    = 4'he;
    localparam logic       ETHMH_BANK_CTRL     = 1'b0;
    localparam logic       ETHMH_BANK_HASH     = 1'b1;
    localparam int         ETHMH_BANK_BIT      = 4;
    localparam int         ETHMH_ADDR_W        = 5;

    localparam int         ETHMH_EN_BIT        = 7;
    localparam int         ETHMH_TH_MSB        = 4;
    localparam int         ETHMH_TH_W          = 5;
    localparam int         ETHMH_RXALL_BIT     = 0;
    localparam int         ETHMH_RXMC_BIT      = 1;
    localparam int         ETHMH_UNIT_SHIFT    = 6;

    localparam logic [4:0]  ETHMH_ETX_TH_RST   = 5'h00;
    localparam logic [4:0]  ETHMH_ERX_TH_RST   = 5'h1f;
    localparam logic [15:0] ETHMH_HASH_RST     = 16'h0000;
    localparam logic [31:0] ETHMH_CRC_POLY     = 32'h04c11db7;
    localparam logic [31:0] ETHMH_CRC_INIT     = 32'hffffffff;

endpackage : ethmh_pkg

// >>> rtl/ethmh_top.sv
// Purpose: Early transmit/receive thresholds and multicast hash filter of an Ethernet MAC
// Assumes: Avalon-MM slave, one wait state on every access; queue logic pulses once per byte written
// Notes:   Bank bit in address picks the control bank or the hash table bank
// Notes on behaviour
// - Early transmit works only while its enable bit 7 is one.
// - Transmit starts once written bytes exceed threshold times 64.
// - Early receive works only while its enable bit 7 is one.
// - Early receive status and interrupt rise once bytes exceed threshold times 64.
// - Receive threshold resets to all ones; zero while enabled is undefined.
// - Hash table is 64 bits in four 16-bit words, reset to zero.
// - Hash index is the top six CRC bits over the destination address.
// - Index top two bits pick the word, low four pick the bit.
// - Multicast frame with its table bit set is accepted.
// - Multicast frame with its table bit clear is dropped.
// - Receive-all or receive-all-multicast flag accepts every multicast frame.
// - Words two and three sit at offsets 0x04 and 0x06 of the hash bank.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module ethmh_top
    import ethmh_pkg::*;
#(
    parameter int CNT_W = 11 // Width of per-frame byte counters
) (
    input  wire logic                    clk,               // 200 MHz clock
    input  wire logic                    rstn,              // Synchronous reset, active low
    input  wire logic [ETHMH_ADDR_W-1:0] avs_address,       // Word address, bit 4 selects bank
    input  wire logic                    avs_read,          // Read request
    input  wire logic                    avs_write,         // Write request
    input  wire logic [31:0]             avs_writedata,     // Write data, low 16 bits used
    input  wire logic [3:0]              avs_byteenable,    // Byte lanes
    output logic [31:0]                  avs_readdata,      // Read data
    output logic                         avs_waitrequest,   // Stall until access done
    input  wire logic                    tx_frame_start,    // Pulse, new transmit frame begins
    input  wire logic                    tx_byte_valid,     // Byte written into transmit memory
    output logic                         tx_early_start,    // Level, frame may go on the wire
    input  wire logic                    rx_frame_start,    // Pulse, new receive frame begins
    input  wire logic                    rx_byte_valid,     // Byte written into receive memory
    input  wire logic                    rx_early_irq_en,   // Early receive interrupt enable
    output logic                         rx_early_status,   // Sticky early receive status
    output logic                         rx_early_irq,      // Early receive interrupt level
    input  wire logic                    da_valid,          // Pulse, destination address ready
    input  wire logic [47:0]             da_addr,           // Destination address
    output logic                         mc_decision_valid, // Pulse, verdict ready
    output logic                         mc_accept,         // Verdict: keep multicast frame
    output logic                         mc_drop            // Verdict: drop multicast frame
);
    // Register state
    logic                  etx_en_q;
    logic [ETHMH_TH_W-1:0] etx_th_q;
    logic                  erx_en_q;
    logic [ETHMH_TH_W-1:0] erx_th_q;
    logic                  rx_all_q;
    logic                  rx_mc_q;
    logic [15:0]           hash_q [4];

    // Frame counters and outputs
    logic [CNT_W-1:0]      tx_cnt_q;
    logic [CNT_W-1:0]      rx_cnt_q;
    logic                  tx_early_q;
    logic                  rx_status_q;
    logic                  rx_irq_q;
    logic                  dec_valid_q;
    logic                  accept_q;
    logic                  drop_q;
    logic                  ack_q;
    logic                  wait_q;
    logic [31:0]           rdata_q;

    // Bus decode
    wire        req        = (avs_read | avs_write) & ~ack_q;
    wire        wr_go      = avs_write & ack_q;
    wire        bank_hash  = avs_address[ETHMH_BANK_BIT] == ETHMH_BANK_HASH;
    wire [3:0]  idx        = avs_address[3:0];
    wire        sel_etx    = ~bank_hash & (idx == ETHMH_IDX_ETX);
    wire        sel_erx    = ~bank_hash & (idx == ETHMH_IDX_ERX);
    wire        sel_rxctl  = ~bank_hash & (idx == ETHMH_IDX_RXCTL);
    wire        sel_stat   = ~bank_hash & (idx == ETHMH_IDX_STATUS);
    wire [3:0]  sel_hash;
    wire        be_lo      = avs_byteenable[0];
    wire        be_hi      = avs_byteenable[1];
    wire        stat_clear = wr_go & sel_stat & be_lo & avs_writedata[0];
    wire        wr_etx     = wr_go & be_lo & sel_etx;
    wire        wr_erx     = wr_go & be_lo & sel_erx;
    wire        wr_rxctl   = wr_go & be_lo & sel_rxctl;

    // Hash bank word selects, one entry per table word
    localparam logic [3:0] HASH_IDX [4] = '{ETHMH_IDX_HASH0, ETHMH_IDX_HASH1, ETHMH_IDX_HASH2, ETHMH_IDX_HASH3};
    for (genvar w = 0; w < 4; w++) begin : g_hash_sel
        assign sel_hash[w] = bank_hash & (idx == HASH_IDX[w]);
    end

    // Threshold comparisons in 64-byte units
    // A zero threshold lets the first byte fire the flag; the host must avoid it
    wire [CNT_W-1:0] etx_limit = CNT_W'({etx_th_q, ETHMH_UNIT_SHIFT'(0)});
    wire [CNT_W-1:0] erx_limit = CNT_W'({erx_th_q, ETHMH_UNIT_SHIFT'(0)});
    wire tx_cross = etx_en_q & (tx_cnt_q > etx_limit);
    wire rx_cross = erx_en_q & (rx_cnt_q > erx_limit);

    // Hash lookup
    ethmh_hash_if hif ();
    assign hif.dest_addr = da_addr;
    ethmh_crc_hash u_hash (
        .hif (hif)
    );
    wire [1:0]  hw_sel   = hif.hash_index[5:4];
    wire [3:0]  hb_sel   = hif.hash_index[3:0];
    wire [15:0] hw_word  = hash_q[hw_sel];
    wire        hash_hit = hw_word[hb_sel];
    wire        bypass   = rx_all_q | rx_mc_q;
    wire        keep     = bypass | hash_hit;

    // Read mux
    wire [15:0] etx_rd  = {8'h00, etx_en_q, 2'b00, etx_th_q};
    wire [15:0] erx_rd  = {8'h00, erx_en_q, 2'b00, erx_th_q};
    wire [15:0] ctl_rd  = {14'h0000, rx_mc_q, rx_all_q};
    wire [15:0] stat_rd = {13'h0000, rx_irq_q, tx_early_q, rx_status_q};
    wire [15:0] rd_mux  = sel_etx      ? etx_rd :
                          sel_erx      ? erx_rd :
                          sel_rxctl    ? ctl_rd :
                          sel_stat     ? stat_rd :
                          sel_hash[0]  ? hash_q[0] :
                          sel_hash[1]  ? hash_q[1] :
                          sel_hash[2]  ? hash_q[2] :
                          sel_hash[3]  ? hash_q[3] : 16'h0000;

    // Bus handshake: first cycle stalls, second completes
    // The wait flag has its own flop so the port is a register, not an inverter
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ack_q  <= 1'b0;
            wait_q <= 1'b1;
        end else begin
            ack_q  <= req;
            wait_q <= ~req;
        end
    end

    // Read data is caught at the stalling edge and stands until the next access
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_q <= 32'h00000000;
        end else if (req) begin
            rdata_q <= {16'h0000, rd_mux};
        end
    end

    // Early transmit control; reserved bits are not stored and read back as zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            etx_en_q <= 1'b0;
            etx_th_q <= ETHMH_ETX_TH_RST;
        end else if (wr_etx) begin
            etx_en_q <= avs_writedata[ETHMH_EN_BIT];
            etx_th_q <= avs_writedata[ETHMH_TH_MSB:0];
        end
    end

    // Early receive control; a zero threshold while enabled is not trapped
    always_ff @(posedge clk) begin
        if (!rstn) begin
            erx_en_q <= 1'b0;
            erx_th_q <= ETHMH_ERX_TH_RST;
        end else if (wr_erx) begin
            erx_en_q <= avs_writedata[ETHMH_EN_BIT];
            erx_th_q <= avs_writedata[ETHMH_TH_MSB:0];
        end
    end

    // Receive control flags that bypass the hash table
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_all_q <= 1'b0;
            rx_mc_q  <= 1'b0;
        end else if (wr_rxctl) begin
            rx_all_q <= avs_writedata[ETHMH_RXALL_BIT];
            rx_mc_q  <= avs_writedata[ETHMH_RXMC_BIT];
        end
    end

    // Hash table words, one per generate entry
    for (genvar w = 0; w < 4; w++) begin : g_hash
        always_ff @(posedge clk) begin
            if (!rstn) begin
                hash_q[w] <= ETHMH_HASH_RST;
            end else if (wr_go && sel_hash[w]) begin
                if (be_lo) hash_q[w][7:0]  <= avs_writedata[7:0];
                if (be_hi) hash_q[w][15:8] <= avs_writedata[15:8];
            end
        end
    end

    // Transmit side byte count; saturates so a long frame cannot wrap below the limit
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_cnt_q <= '0;
        end else if (tx_frame_start) begin
            tx_cnt_q <= '0;
        end else if (tx_byte_valid && tx_cnt_q != '1) begin
            tx_cnt_q <= tx_cnt_q + CNT_W'(1);
        end
    end

    // Early start holds until the next frame begins
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_early_q <= 1'b0;
        end else if (tx_frame_start) begin
            tx_early_q <= 1'b0;
        end else begin
            tx_early_q <= tx_early_q | tx_cross;
        end
    end

    // Receive side byte count
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_cnt_q <= '0;
        end else if (rx_frame_start) begin
            rx_cnt_q <= '0;
        end else if (rx_byte_valid && rx_cnt_q != '1) begin
            rx_cnt_q <= rx_cnt_q + CNT_W'(1);
        end
    end

    // Early receive status is sticky; set wins over a software clear in the same cycle
    wire rx_status_d = rx_cross | (rx_status_q & ~stat_clear);
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_status_q <= 1'b0;
        end else begin
            rx_status_q <= rx_status_d;
        end
    end

    // Interrupt follows the status it will show, gated by its enable
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_irq_q <= 1'b0;
        end else begin
            rx_irq_q <= rx_status_d & rx_early_irq_en;
        end
    end

    // Filter verdict; accept and drop hold until the next address
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dec_valid_q <= 1'b0;
            accept_q    <= 1'b0;
            drop_q      <= 1'b0;
        end else begin
            dec_valid_q <= da_valid;
            if (da_valid) begin
                accept_q <= keep;
                drop_q   <= ~keep;
            end
        end
    end

    assign avs_readdata      = rdata_q;
    assign avs_waitrequest   = wait_q;
    assign tx_early_start    = tx_early_q;
    assign rx_early_status   = rx_status_q;
    assign rx_early_irq      = rx_irq_q;
    assign mc_decision_valid = dec_valid_q;
    assign mc_accept         = accept_q;
    assign mc_drop           = drop_q;

endmodule : ethmh_top

// >>> test/early_threshold_multicast_hash_tb.sv
// Purpose: Self-checking bench for the early threshold and hash block
// Assumes: Fixed xorshift seed, Avalon master waits on waitrequest
// Notes:   Expected hash index is worked out here bit by bit
`timescale 1ns/1ps
module early_threshold_multicast_hash_tb;
    import ethmh_pkg::*;
    localparam logic [4:0] A_TAB [6] = '{5'h08, 5'h0a, 5'h10, 5'h12, 5'h14, 5'h16};
    logic clk, rstn, avs_read, avs_write, avs_waitrequest, da_valid, rx_early_irq_en, go, is_rx, slow;
    logic tx_early_start, rx_early_status, rx_early_irq, mc_decision_valid, mc_accept, mc_drop, fs, bv, busy;
    logic [4:0]  avs_address, th;
    logic [31:0] avs_writedata, avs_readdata, q, seed;
    logic [47:0] da_addr, da;
    logic [10:0] nbytes;
    logic [15:0] ht [4];
    logic [5:0]  idx;
    logic        en, ex;
    int          n_mismatch, compares, cyc, n;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ethmh_top ethmh_top_i (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .tx_frame_start(fs && !is_rx),
        .tx_byte_valid(bv && !is_rx), .tx_early_start, .rx_frame_start(fs && is_rx),
        .rx_byte_valid(bv && is_rx), .rx_early_irq_en, .rx_early_status, .rx_early_irq, .da_valid,
        .da_addr, .mc_decision_valid, .mc_accept, .mc_drop);
    ethmh_queue_model ethmh_queue_model_i (.clk, .rstn, .start(go), .slow, .nbytes, .frame_start(fs),
        .byte_valid(bv), .busy);

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function logic [5:0] hidx(input logic [47:0] a);
        logic [31:0] c;
        c = ETHMH_CRC_INIT;
        for (int i = 0; i < 48; i++) c = (c[31] ^ a[i]) ? {c[30:0], 1'b0} ^ ETHMH_CRC_POLY : {c[30:0], 1'b0};
        return c[31:26];
    endfunction : hidx

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {16'h0000, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic frame(input logic rx, input int len);
        @(posedge clk);
        is_rx <= rx;
        nbytes <= 11'(len);
        slow <= rnd() > 32'h80000000;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (busy !== 1'b0);
        repeat (3) @(posedge clk);
    endtask : frame

    task final_report();
        $display("Mismatches %0d comparisons %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // Budget covers six frames of at most 232 bytes at half rate plus register traffic
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        {rstn, avs_read, avs_write, da_valid, rx_early_irq_en, go, is_rx, slow} = '0;
        {avs_address, avs_writedata, da_addr, nbytes} = '0;
        {n_mismatch, compares, cyc, seed} = {96'h0, 32'd32121};
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, A_TAB[i], 16'h0000);
            check("reset_value", (i == 1) ? 32'h1f : 32'h0, q);
            bus(1'b1, A_TAB[i], (i < 2) ? 16'hffff : 16'(rnd()));
            if (i > 1) ht[i-2] = avs_writedata[15:0];
            bus(1'b0, A_TAB[i], 16'h0000);
            check("reg_readback", (i < 2) ? 32'h9f : {16'h0, ht[i-2]}, q);
        end
        bus(1'b1, 5'h1e, 16'hffff);
        bus(1'b0, 5'h1e, 16'h0000);
        check("unmapped", 32'h0, q);
        for (int i = 0; i < 6; i++) begin
            th = 5'(rnd() % 3 + 1);
            en = (i % 3) != 2;
            n = th * 64 + ((i % 3 == 0) ? 0 : (en ? 1 : 40));
            bus(1'b1, (i > 2) ? 5'h0a : 5'h08, {8'h00, en, 2'b00, th});
            bus(1'b1, 5'h0e, 16'h0001);
            rx_early_irq_en <= (i % 3) != 0;
            frame(i > 2, n);
            ex = en && (n > th * 64);
            if (i > 2) begin
                check("rx_status", {31'h0, ex}, {31'h0, rx_early_status});
                check("rx_irq", {31'h0, ex && (i % 3) != 0}, {31'h0, rx_early_irq});
                bus(1'b0, 5'h0e, 16'h0000);
                check("status_reg", {29'h0, ex && (i % 3) != 0, 1'b0, ex}, q);
            end else check("tx_early", {31'h0, ex}, {31'h0, tx_early_start});
        end
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 5'h0c, 16'(m));
            repeat (16) begin
                da = {16'(rnd()), rnd()} | 48'h1;
                idx = hidx(da);
                @(posedge clk);
                da_addr <= da;
                da_valid <= 1'b1;
                @(posedge clk);
                da_valid <= 1'b0;
                do @(posedge clk); while (mc_decision_valid !== 1'b1);
                ex = (m != 0) || ht[idx[5:4]][idx[3:0]];
                check("mc_accept", {31'h0, ex}, {31'h0, mc_accept});
                check("mc_drop", {31'h0, !ex}, {31'h0, mc_drop});
            end
        end
        final_report();
    end
endmodule : early_threshold_multicast_hash_tb

// >>> test/ethmh_queue_model.sv
// Purpose: Queue logic that writes frame bytes into buffer memory
// Assumes: Driven from the bench, one frame at a time
// Notes:   Slow mode writes a byte every other cycle
`timescale 1ns/1ps
module ethmh_queue_model (
    input wire logic        clk,         // Clock
    input wire logic        rstn,        // Reset, active low
    input wire logic        start,       // Begin a frame
    input wire logic        slow,        // Half byte rate
    input wire logic [10:0] nbytes,      // Frame length
    output logic            frame_start, // Frame start pulse
    output logic            byte_valid,  // Byte written
    output logic            busy         // Frame in progress
);
    logic [10:0] cnt_q;
    logic        tick_q;
    always_ff @(posedge clk) begin
        frame_start <= 1'b0;
        byte_valid <= 1'b0;
        tick_q <= ~tick_q;
        if (!rstn) begin
            cnt_q <= 11'h000;
            busy <= 1'b0;
            tick_q <= 1'b0;
        end else if (start && !busy) begin
            frame_start <= 1'b1;
            cnt_q <= nbytes;
            busy <= 1'b1;
        end else if (busy && cnt_q == 11'h000) begin
            busy <= 1'b0;
        end else if (busy && (!slow || tick_q)) begin
            byte_valid <= 1'b1;
            cnt_q <= cnt_q - 11'h001;
        end
    end
endmodule : ethmh_queue_model

// >>> test/ethmh_top_asserts.sv
// Purpose: Port-level checks of the early threshold and hash block
// Assumes: One clock, synchronous active-low reset
// Notes:   Sees only top ports; bound after the module
`timescale 1ns/1ps
module ethmh_top_asserts
    import ethmh_pkg::*;
(
    input wire logic        clk,               // Clock
    input wire logic        rstn,              // Reset, active low
    input wire logic [4:0]  avs_address,       // Word address
    input wire logic        avs_read,          // Read request
    input wire logic        avs_write,         // Write request
    input wire logic [31:0] avs_readdata,      // Read data
    input wire logic        avs_waitrequest,   // Stall
    input wire logic        tx_frame_start,    // Tx frame begins
    input wire logic        tx_early_start,    // Tx early start
    input wire logic        rx_early_irq_en,   // Irq enable
    input wire logic        rx_early_status,   // Rx early status
    input wire logic        rx_early_irq,      // Rx early irq
    input wire logic        da_valid,          // Address ready
    input wire logic        mc_decision_valid, // Verdict ready
    input wire logic        mc_accept,         // Keep frame
    input wire logic        mc_drop            // Drop frame
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire req = avs_read || avs_write;
    wire thr_rd = avs_read && !avs_waitrequest && (avs_address == 5'h08 || avs_address == 5'h0a);
    sequence s_req_seen;
        req && avs_waitrequest;
    endsequence
    sequence s_done;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    chk_wait_answer: assert property (s_req_seen |=> s_done)
        else $error("access not answered after one cycle");
    chk_wait_idle: assert property (!req |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    chk_thresh_rsvd: assert property (thr_rd |-> avs_readdata[31:8] == 24'h000000 && avs_readdata[6:5] == 2'h0)
        else $error("reserved threshold bits not zero");
    chk_verdict_cause: assert property (mc_decision_valid |-> $past(da_valid))
        else $error("verdict without address");
    chk_verdict_time: assert property (da_valid |=> mc_decision_valid)
        else $error("verdict late");
    chk_verdict_excl: assert property (mc_decision_valid |-> mc_accept != mc_drop)
        else $error("accept and drop agree");
    chk_tx_clear: assert property (tx_frame_start |=> !tx_early_start)
        else $error("early start survives frame start");
    chk_irq_gate: assert property (!rx_early_irq_en [*2] |-> !rx_early_irq)
        else $error("irq while disabled");
    chk_status_sticky: assert property (rx_early_status && !(avs_write && avs_address == 5'h0e) |=> rx_early_status)
        else $error("status lost without clear");
endmodule : ethmh_top_asserts

bind ethmh_top ethmh_top_asserts ethmh_top_asserts_i (.clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .tx_frame_start, .tx_early_start, .rx_early_irq_en, .rx_early_status,
    .rx_early_irq, .da_valid, .mc_decision_valid, .mc_accept, .mc_drop);
